// ==== rtl/asram_cycle_timer.v ====
// Down counter that times each strobe phase in whole clock cycles
`timescale 1ns/1ps
module asram_cycle_timer #(
  parameter WIDTH = 4
) (
  input wire core_clk,
  input wire rstSync_b,
  input wire load,
  input wire [WIDTH-1:0] loadValue,
  output reg done
);
  reg [WIDTH-1:0] count;
  always @(posedge core_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count <= {WIDTH{1'b0}};
      done <= 1'b1;
    end else if (load) begin
      count <= loadValue;
      done <= (loadValue == {WIDTH{1'b0}});
    end else if (count != {WIDTH{1'b0}}) begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      done <= (count == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule

// ==== rtl/asram_host.v ====
// Host controller driving an asynchronous byte-wide static memory
`timescale 1ns/1ps
`include "asram_timing_map.vh"
module asram_host #(
  parameter AW = `ASRAM_ADDR_WIDTH,
  parameter DW = `ASRAM_DATA_WIDTH
) (
  input wire core_clk,
  input wire rst_b,
  input wire reqValid,
  input wire reqWrite,
  input wire [AW-1:0] reqAddr,
  input wire [DW-1:0] reqWdata,
  input wire retainReq,
  output reg reqReady,
  output reg rspValid,
  output reg [DW-1:0] rspRdata,
  output reg retainOk,
  output reg [AW-1:0] memAddr,
  output reg memCs_b,
  output reg memOe_b,
  output reg memWe_b,
  output reg [DW-1:0] memDataOut,
  output reg memDataOe_b,
  input wire [DW-1:0] memDataIn
);
  // Counts are whole cycles; only the timer's four bits are kept
  localparam integer READ_N = `ASRAM_READ_CYC;
  localparam integer WRITE_N = `ASRAM_WRITE_CYC;
  localparam integer TURN_N = `ASRAM_TURN_CYC;
  localparam [3:0] LD_READ = READ_N[3:0];
  localparam [3:0] LD_WRITE = WRITE_N[3:0];
  localparam [3:0] LD_TURN = TURN_N[3:0];

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RSTB = 5'h02;
  localparam [4:0] ST_WSTB = 5'h04;
  localparam [4:0] ST_TURN = 5'h08;
  localparam [4:0] ST_RET = 5'h10;

  reg rstMeta_b;
  reg rstSync_b;
  reg [4:0] state;
  reg [DW-1:0] din1;
  reg [DW-1:0] din2;
  reg [DW-1:0] din3;
  reg timerLoad;
  reg [3:0] timerValue;
  wire timerDone;
  wire pinsAgree;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // Read data crosses from the pins; sample once stage two and three agree
  always @(posedge core_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      din1 <= {DW{1'b0}};
      din2 <= {DW{1'b0}};
      din3 <= {DW{1'b0}};
    end else begin
      din1 <= memDataIn;
      din2 <= din1;
      din3 <= din2;
    end
  end

  assign pinsAgree = (din2 == din3);

  // Timer output is stale in the cycle after a load
  function phaseDone;
    input doneIn;
    input loadIn;
    begin
      phaseDone = doneIn && !loadIn;
    end
  endfunction

  asram_cycle_timer #(.WIDTH(4)) uTimer (
    .core_clk(core_clk),
    .rstSync_b(rstSync_b),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  always @(posedge core_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      state <= ST_IDLE;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspRdata <= {DW{1'b0}};
      retainOk <= 1'b0;
      memAddr <= {AW{1'b0}};
      memCs_b <= 1'b1;
      memOe_b <= 1'b1;
      memWe_b <= 1'b1;
      memDataOut <= {DW{1'b0}};
      memDataOe_b <= 1'b1;
      timerLoad <= 1'b0;
      timerValue <= 4'h0;
    end else begin
      timerLoad <= 1'b0;
      rspValid <= 1'b0;
      reqReady <= 1'b0;
      // One-hot phases: idle, read, write, turnaround, retention
      case (state)
        ST_IDLE: begin
          if (retainReq) begin
            memCs_b <= 1'b1;
            state <= ST_RET;
          end else if (reqValid && !reqReady) begin
            // Ready pulses for one cycle; a request still held on the return to idle is taken again
            reqReady <= 1'b1;
            memAddr <= reqAddr;
            memCs_b <= 1'b0;
            timerLoad <= 1'b1;
            if (reqWrite) begin
              // Drive only with output enable high
              memOe_b <= 1'b1;
              memWe_b <= 1'b0;
              memDataOut <= reqWdata;
              memDataOe_b <= 1'b0;
              timerValue <= LD_WRITE;
              state <= ST_WSTB;
            end else begin
              memOe_b <= 1'b0;
              // Fixed wait trades some speed for no ready pin
              // Wait access plus sync delay
              timerValue <= LD_READ;
              state <= ST_RSTB;
            end
          end
        end

        ST_RSTB: begin
          // Wait while stages two and three still differ
          if (phaseDone(timerDone, timerLoad) && pinsAgree) begin
            rspRdata <= din3;
            rspValid <= 1'b1;
            memCs_b <= 1'b1;
            memOe_b <= 1'b1;
            timerLoad <= 1'b1;
            timerValue <= LD_TURN;
            state <= ST_TURN;
          end
        end

        ST_WSTB: begin
          if (phaseDone(timerDone, timerLoad)) begin
            memWe_b <= 1'b1;
            memCs_b <= 1'b1;
            rspValid <= 1'b1;
            timerLoad <= 1'b1;
            timerValue <= LD_TURN;
            state <= ST_TURN;
          end
        end

        ST_TURN: begin
          // Data held one cycle past the write end, then released
          memDataOe_b <= 1'b1;
          if (phaseDone(timerDone, timerLoad)) begin
            state <= ST_IDLE;
          end
        end

        ST_RET: begin
          // Requests wait here until retention is dropped
          retainOk <= retainReq;
          if (!retainReq) begin
            state <= ST_IDLE;
          end
        end

        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== rtl/asram_timing_map.vh ====
// Timing and geometry constants for the asynchronous static memory host
`ifndef ASRAM_TIMING_MAP_VH
`define ASRAM_TIMING_MAP_VH
`define ASRAM_CLK_PERIOD_NS 10
`define ASRAM_ADDR_WIDTH 19
`define ASRAM_DATA_WIDTH 8
`define ASRAM_READ_CYCLE_NS 12
`define ASRAM_ACCESS_NS 12
`define ASRAM_OE_ACCESS_NS 6
`define ASRAM_HOLD_NS 3
`define ASRAM_OFF_NS 6
`define ASRAM_WRITE_CYCLE_NS 12
`define ASRAM_WRITE_PULSE_NS 8
`define ASRAM_DATA_SETUP_NS 6
`define ASRAM_WE_LOWZ_NS 3
`define ASRAM_CEIL(t) (((t) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_READ_CYC `ASRAM_CEIL(`ASRAM_ACCESS_NS + `ASRAM_CLK_PERIOD_NS)
`define ASRAM_WRITE_CYC `ASRAM_CEIL(`ASRAM_WRITE_PULSE_NS)
`define ASRAM_TURN_CYC `ASRAM_CEIL(`ASRAM_OFF_NS)
`endif

// ==== test/asat_host_assertions.sv ====
// Pin protocol checker for the static memory host
`timescale 1ns/1ps
module asat_host_chk (
  input wire core_clk,
  input wire rst_b,
  input wire reqReady,
  input wire rspValid,
  input wire retainOk,
  input wire [18:0] memAddr,
  input wire memCs_b,
  input wire memOe_b,
  input wire memWe_b,
  input wire memDataOe_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_write_under_cs: assert property (!memWe_b |-> !memCs_b)
    else $error("write strobe without select");
  a_write_pulse: assert property ($fell(memWe_b) |->
    !memWe_b [*3] ##1 memWe_b) else $error("write pulse length");
  a_cs_setup: assert property ($rose(memWe_b) |->
    !$past(memCs_b, 2)) else $error("select too short");
  a_addr_hold: assert property (!memWe_b && !$past(memWe_b) |->
    $stable(memAddr)) else $error("address moved in write");
  a_data_setup: assert property ($rose(memWe_b) |->
    !memDataOe_b && !$past(memDataOe_b, 2)) else $error("data window");
  a_no_clash: assert property (!memOe_b |-> memDataOe_b)
    else $error("host drives during read");
  a_read_answer: assert property (reqReady && !memOe_b |->
    ##5 rspValid && memOe_b) else $error("read answer timing");
  a_write_answer: assert property (reqReady && !memWe_b |->
    ##3 rspValid && memWe_b) else $error("write answer timing");
  a_retain_off: assert property (retainOk |-> memCs_b)
    else $error("selected while retained");
endmodule
bind asram_host asat_host_chk i_chk (.core_clk(core_clk), .rst_b(rst_b),
  .reqReady(reqReady), .rspValid(rspValid), .retainOk(retainOk),
  .memAddr(memAddr), .memCs_b(memCs_b), .memOe_b(memOe_b),
  .memWe_b(memWe_b), .memDataOe_b(memDataOe_b));

// ==== test/asat_sram_model.sv ====
// Behavioural static memory on the far side of the host pins
`timescale 1ns/1ps
module asat_sram_model (
  input wire [18:0] memAddr,
  input wire memCs_b,
  input wire memOe_b,
  input wire memWe_b,
  input wire memDataOe_b,
  input wire [7:0] busIn,
  output wire [7:0] memDataIn
);
  reg [7:0] mem [0:524287];
  reg [7:0] held = 8'h00;
  reg [18:0] wAddr;
  reg [7:0] wData;
  wire [7:0] devQ;
  wire wr = !memCs_b && !memWe_b;
  wire rd = !memCs_b && !memOe_b && memWe_b;
  always @* if (rd) held = mem[memAddr];
  assign #5 devQ = rd ? held : ~held;
  assign memDataIn = !memDataOe_b ? busIn : devQ;
  // write window opens only with both strobes low
  always @* if (wr) begin
    wAddr = memAddr;
    wData = busIn;
  end
  // stored when the first rising strobe closes the window
  always @(negedge wr) mem[wAddr] <= wData;
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the static memory host
`timescale 1ns/1ps
module tb;
  reg core_clk = 1'b0;
  reg rst_b = 1'b0;
  reg reqValid = 1'b0;
  reg reqWrite = 1'b0;
  reg [18:0] reqAddr = 19'h00000;
  reg [7:0] reqWdata = 8'h00;
  reg retainReq = 1'b0;
  wire reqReady, rspValid, retainOk, memCs_b, memOe_b, memWe_b;
  wire memDataOe_b;
  wire [7:0] rspRdata, memDataOut, memDataIn;
  wire [18:0] memAddr;
  reg [7:0] shadow [0:524287];
  reg [18:0] a;
  reg seen;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int i;
  always #5 core_clk = ~core_clk;
  asram_host i_dut (.core_clk(core_clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .retainReq(retainReq), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .retainOk(retainOk), .memAddr(memAddr),
    .memCs_b(memCs_b), .memOe_b(memOe_b), .memWe_b(memWe_b),
    .memDataOut(memDataOut), .memDataOe_b(memDataOe_b),
    .memDataIn(memDataIn));
  asat_sram_model i_mem (.memAddr(memAddr), .memCs_b(memCs_b),
    .memOe_b(memOe_b), .memWe_b(memWe_b), .memDataOe_b(memDataOe_b),
    .busIn(memDataOut), .memDataIn(memDataIn));
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task check(input string nm, input [7:0] e, input [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function [7:0] expRead(input [18:0] ad);
    return shadow[ad];
  endfunction
  task op(input w, input [18:0] ad, input [7:0] d);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqWrite <= w;
    reqAddr <= ad;
    reqWdata <= d;
    do @(posedge core_clk); while (reqReady !== 1'b1 && n++ < 30);
    check("reqReady", 8'h01, {7'h00, reqReady});
    reqValid <= 1'b0;
    n = 0;
    do @(posedge core_clk); while (rspValid !== 1'b1 && n++ < 30);
    check("rspValid", 8'h01, {7'h00, rspValid});
    if (w) shadow[ad] = d;
    else check("rspRdata", expRead(ad), rspRdata);
  endtask
  // Hang guard, well beyond the roughly 1060 cycles the test needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      print_verdict;
    end
  end
  initial begin
    i = $urandom(61934);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    op(1'b1, 19'h00000, 8'hff);
    op(1'b1, 19'h7ffff, 8'h00);
    op(1'b0, 19'h00000, 8'h00);
    op(1'b0, 19'h7ffff, 8'h00);
    for (i = 0; i < 40; i++) begin
      a = 19'($urandom);
      op(1'b1, a, 8'($urandom));
      op(1'b0, a, 8'h00);
      op(1'b0, 19'h00000, 8'h00);
    end
    retainReq <= 1'b1;
    reqValid <= 1'b1;
    seen = 1'b0;
    repeat (8) @(posedge core_clk) seen = seen | (reqReady === 1'b1);
    check("reqReady", 8'h00, {7'h00, seen});
    check("retainOk", 8'h01, {7'h00, retainOk});
    retainReq <= 1'b0;
    op(1'b1, 19'h00005, 8'ha5);
    op(1'b0, 19'h00005, 8'h00);
    print_verdict;
  end
endmodule
